// file: shared/fpri_pkg.sv
// Shared constants and types for the floating-point round-to-integral unit
package fpri_pkg;
	// Register byte offsets on the APB bus
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATCTL = 8'h04;
	localparam logic [7:0] OFS_OPLO = 8'h08;
	localparam logic [7:0] OFS_OPHI = 8'h0c;
	localparam logic [7:0] OFS_CMD = 8'h10;
	localparam logic [7:0] OFS_RESLO = 8'h14;
	localparam logic [7:0] OFS_RESHI = 8'h18;
	localparam logic [7:0] OFS_RESINFO = 8'h1c;
	localparam logic [7:0] OFS_IRQSTAT = 8'h20;
	localparam logic [7:0] OFS_IRQMASK = 8'h24;
	// Status/control register fields
	localparam int RMODE_LSB = 22;
	localparam int DN_BIT = 25;
	localparam int IOC_BIT = 0;
	localparam int OFC_BIT = 2;
	localparam int UFC_BIT = 3;
	localparam int IXC_BIT = 4;
	localparam logic [31:0] STATCTL_RESET = 32'h0000_0000;
	// Rounding mode codes as held in the status/control register
	localparam logic [1:0] RND_NEAREST = 2'h0;
	localparam logic [1:0] RND_PLUS = 2'h1;
	localparam logic [1:0] RND_MINUS = 2'h2;
	localparam logic [1:0] RND_ZERO = 2'h3;
	// Interrupt status bit positions
	localparam int IRQ_W = 6;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_UNDEF = 1;
	localparam int IRQ_INVALID = 2;
	localparam int IRQ_OVERFLOW = 3;
	localparam int IRQ_UNDERFLOW = 4;
	localparam int IRQ_INEXACT = 5;
	// Default quiet NaN patterns
	localparam logic [63:0] DNAN_DP = 64'h7ff8_0000_0000_0000;
	localparam logic [31:0] DNAN_SP = 32'h7fc0_0000;
	// Instruction variant classes
	typedef enum logic [1:0]
	{
		VAR_DIRECTED = 2'b00,
		VAR_EXACT = 2'b01,
		VAR_ZEROSTAT = 2'b10
	} fpri_variant_t;
	// Command word, written to the command register (bit 15 first)
	typedef struct packed
	{
		logic srcHi;
		logic [3:0] source_reg_index;
		logic dstHi;
		logic [3:0] destination_reg_index;
		logic precision_select_bit;
		logic truncate_select_bit;
		logic [1:0] directed_round_select;
		logic [1:0] variant;
	} fpri_cmd_t;
	// Floating-point exception flags of one operation
	typedef struct packed
	{
		logic inexact;
		logic underflow;
		logic overflow;
		logic invalid;
	} fpri_flags_t;
endpackage

// file: src/fpri_rounder.sv
// Combinational round-to-integral datapath for single and double operands
`timescale 1ns/100ps
module fpri_rounder
	import fpri_pkg::*;
(
	input wire logic dp,
	input wire logic [63:0] operand,
	input wire logic [1:0] rmode,
	input wire logic away,
	input wire logic exactEn,
	input wire logic defaultNan,
	output logic [63:0] result,
	output fpri_flags_t flags
);
	// Unpacked fields, significand left-aligned to 53 bits for both formats
	logic sgn;
	logic [10:0] expF;
	logic [51:0] frac;
	logic [52:0] sig;
	logic signed [12:0] ue;
	logic isNan;
	logic isInf;
	logic isZero;
	logic [5:0] s;
	logic [52:0] keep;
	logic [52:0] intSig;
	logic half;
	logic sticky;
	logic lsb;
	logic up;
	logic [53:0] sum;
	logic [10:0] expO;
	logic [51:0] fracO;
	logic [63:0] packed_r;

	always_comb
	begin
		// Unpack per precision
		sgn = dp ? operand[63] : operand[31];
		expF = dp ? operand[62:52] : {3'h0, operand[30:23]};
		frac = dp ? operand[51:0] : {operand[22:0], 29'h0};
		isNan = dp ? (&operand[62:52] && |operand[51:0]) : (&operand[30:23] && |operand[22:0]);
		isInf = dp ? (&operand[62:52] && ~|operand[51:0]) : (&operand[30:23] && ~|operand[22:0]);
		isZero = (expF == 11'h0) && (frac == 52'h0);
		sig = {1'b1, frac};
		ue = dp ? ($signed({2'b00, expF}) - 13'sd1023) : ($signed({2'b00, expF}) - 13'sd127);
		s = 6'h0;
		keep = 53'h0;
		intSig = 53'h0;
		half = 1'b0;
		sticky = 1'b0;
		lsb = 1'b0;
		up = 1'b0;
		sum = 54'h0;
		expO = expF;
		fracO = frac;
		flags = '0;
		if (isNan)
		begin
			// Signalling NaN raises invalid; result is quiet or default
			flags.invalid = dp ? ~operand[51] : ~operand[22];
			fracO = {1'b1, frac[50:0]};
		end
		else if (isInf || isZero || ue >= (dp ? 13'sd52 : 13'sd23))
		begin
			// Already integral: infinities and zeros keep their sign
		end
		else if (ue < 13'sd0)
		begin
			// Magnitude below one: result is zero or one
			half = (ue == -13'sd1);
			sticky = half ? |frac : 1'b1;
			unique case (rmode)
				RND_NEAREST: up = half && (away || sticky);
				RND_PLUS: up = ~sgn;
				RND_MINUS: up = sgn;
				RND_ZERO: up = 1'b0;
			endcase
			expO = up ? (dp ? 11'd1023 : 11'd127) : 11'h0;
			fracO = 52'h0;
		end
		else
		begin
			// Clear fraction bits below the binary point, then round up
			s = 6'(13'sd52 - ue);
			keep = ~((53'h1 << s) - 53'h1);
			intSig = sig & keep;
			half = sig[s - 6'h1];
			sticky = |(sig & ((53'h1 << (s - 6'h1)) - 53'h1));
			lsb = sig[s];
			unique case (rmode)
				RND_NEAREST: up = half && (away || sticky || lsb);
				RND_PLUS: up = ~sgn && (half || sticky);
				RND_MINUS: up = sgn && (half || sticky);
				RND_ZERO: up = 1'b0;
			endcase
			sum = {1'b0, intSig} + (up ? (54'h1 << s) : 54'h0);
			expO = sum[53] ? expF + 11'h1 : expF;
			fracO = sum[53] ? 52'h0 : sum[51:0];
		end
		packed_r = dp ? {sgn, expO, fracO} : {32'h0, sgn, expO[7:0], fracO[51:29]};
		if (isNan && defaultNan)
			packed_r = dp ? DNAN_DP : {32'h0, DNAN_SP};
		result = packed_r;
		// Rounding to integral cannot overflow or underflow; flags stay low
		flags.inexact = exactEn && !isNan && (packed_r != (dp ? operand : {32'h0, operand[31:0]}));
	end
endmodule

// file: src/fp_round_to_integral.sv
// Round-to-integral execution unit with APB registers and interrupt
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
// Overview of operation
// - Result precision equals operand precision
// - Zero operand returns signed zero unchanged
// - Infinity returns same infinity, no flags
// - NaN propagated and invalid as arithmetic
// - Directed field: away, even, plus, minus
// - Directed and zero/status never flag inexact
// - Current mode uses status bits 23:22
// - Current mode flags inexact on change
// - Truncate bit set forces toward zero
// - Toward zero truncates magnitude
// - Status variant uses register mode, exact off
// - Precision bit one selects double
// - Index formation differs per precision
// - Double on single-only build is undefined
// - Four directed modes implemented
module fp_round_to_integral
	import fpri_pkg::*;
#(
	parameter bit SINGLE_ONLY = 1'b0
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq
);
	// Bus phase tracking: one wait state so read data comes from a flop
	logic ackPhase;
	// Register file
	logic fpAccessEnable;
	logic [31:0] fp_status_control_reg;
	logic [63:0] operand;
	fpri_cmd_t cmd;
	logic [63:0] result;
	logic [4:0] dstIndex;
	logic [4:0] srcIndex;
	fpri_flags_t lastFlags;
	logic lastUndef;
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqMask;
	// Execution pipeline
	logic launch;
	logic doneEvt;
	logic undefEvt;
	fpri_flags_t evtFlags;
	// Datapath wiring
	fpri_cmd_t wcmd;
	logic [1:0] effMode;
	logic effAway;
	logic effExact;
	logic isUndef;
	logic [63:0] rndResult;
	fpri_flags_t rndFlags;
	logic wrEn;
	logic rdSample;
	logic mapped;
	logic [31:0] next_prdata;
	logic [IRQ_W-1:0] irqSet;

	// Bus decode
	assign wrEn = psel && penable && pwrite && pready;
	assign rdSample = psel && penable && !ackPhase;
	assign pready = ackPhase;
	assign wcmd = fpri_cmd_t'(pwdata[15:0]);
	assign launch = wrEn && (paddr == OFS_CMD);

	always_comb
	begin
		// Address map check
		unique case (paddr)
			OFS_CTRL, OFS_STATCTL, OFS_OPLO, OFS_OPHI, OFS_CMD, OFS_RESLO, OFS_RESHI,
			OFS_RESINFO, OFS_IRQSTAT, OFS_IRQMASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	// Error answer on unmapped addresses, in the ready cycle only
	assign pslverr = pready && !mapped;

	// Access phase: first cycle waits, second answers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ackPhase <= 1'b0;
		else
			ackPhase <= psel && penable && !ackPhase;
	end

	always_comb
	begin
		// Read data mux
		next_prdata = 32'h0;
		unique case (paddr)
			OFS_CTRL: next_prdata = {31'h0, fpAccessEnable};
			OFS_STATCTL: next_prdata = fp_status_control_reg;
			OFS_OPLO: next_prdata = operand[31:0];
			OFS_OPHI: next_prdata = operand[63:32];
			OFS_CMD: next_prdata = {16'h0, cmd};
			OFS_RESLO: next_prdata = result[31:0];
			OFS_RESHI: next_prdata = result[63:32];
			OFS_RESINFO: next_prdata = {17'h0, lastUndef, lastFlags, srcIndex,
				dstIndex};
			OFS_IRQSTAT: next_prdata = {{(32-IRQ_W){1'b0}}, irqStatus};
			OFS_IRQMASK: next_prdata = {{(32-IRQ_W){1'b0}}, irqMask};
			default: next_prdata = 32'h0;
		endcase
	end

	// Read data register, loaded in the first access cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			prdata <= 32'h0;
		else if (rdSample && !pwrite)
			prdata <= next_prdata;
	end

	// Plain control registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fpAccessEnable <= 1'b0;
			operand <= 64'h0;
			cmd <= '0;
			irqMask <= '0;
		end
		else if (wrEn)
		begin
			if (paddr == OFS_CTRL)
				fpAccessEnable <= pwdata[0];
			if (paddr == OFS_OPLO)
				operand[31:0] <= pwdata;
			if (paddr == OFS_OPHI)
				operand[63:32] <= pwdata;
			if (paddr == OFS_CMD)
				cmd <= wcmd;
			if (paddr == OFS_IRQMASK)
				irqMask <= pwdata[IRQ_W-1:0];
		end
	end

	always_comb
	begin
		// Rounding mode selection for the command being launched
		effMode = fp_status_control_reg[RMODE_LSB+1:RMODE_LSB];
		effAway = 1'b0;
		effExact = 1'b0;
		unique case (wcmd.variant)
			VAR_DIRECTED:
			begin
				unique case (wcmd.directed_round_select)
					2'b00:
					begin
						effMode = RND_NEAREST;
						effAway = 1'b1;
					end
					2'b01: effMode = RND_NEAREST;
					2'b10: effMode = RND_PLUS;
					2'b11: effMode = RND_MINUS;
				endcase
			end
			VAR_EXACT: effExact = 1'b1;
			VAR_ZEROSTAT:
			begin
				if (wcmd.truncate_select_bit)
					effMode = RND_ZERO;
			end
			default: effExact = 1'b0;
		endcase
	end

	// Trap when access is off, variant code three is given, or double asked of a single-only build
	assign isUndef = !fpAccessEnable
		|| (SINGLE_ONLY && wcmd.precision_select_bit)
		|| (wcmd.variant == 2'b11);

	// Rounding datapath, precision chosen by the command
	fpri_rounder u_rounder
	(
		.dp(wcmd.precision_select_bit),
		.operand(operand),
		.rmode(effMode),
		.away(effAway),
		.exactEn(effExact),
		.defaultNan(fp_status_control_reg[DN_BIT]),
		.result(rndResult),
		.flags(rndFlags)
	);

	// Result capture; a trapped command leaves destination state alone
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			result <= 64'h0;
			dstIndex <= 5'h0;
			srcIndex <= 5'h0;
			lastFlags <= '0;
		end
		else if (launch && !isUndef)
		begin
			result <= rndResult;
			lastFlags <= rndFlags;
			// Double: extra bit on top; single: extra bit at bottom
			dstIndex <= wcmd.precision_select_bit ? {wcmd.dstHi, wcmd.destination_reg_index}
				: {wcmd.destination_reg_index, wcmd.dstHi};
			srcIndex <= wcmd.precision_select_bit ? {wcmd.srcHi, wcmd.source_reg_index}
				: {wcmd.source_reg_index, wcmd.srcHi};
		end
	end

	// One-cycle completion events
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			doneEvt <= 1'b0;
			undefEvt <= 1'b0;
			evtFlags <= '0;
			lastUndef <= 1'b0;
		end
		else
		begin
			doneEvt <= launch && !isUndef;
			undefEvt <= launch && isUndef;
			evtFlags <= (launch && !isUndef) ? rndFlags : '0;
			if (launch)
				lastUndef <= isUndef;
		end
	end

	// Status/control register; cumulative bits set by hardware win over writes
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			fp_status_control_reg <= STATCTL_RESET;
		else
		begin
			if (wrEn && paddr == OFS_STATCTL)
				fp_status_control_reg <= pwdata;
			if (evtFlags.invalid)
				fp_status_control_reg[IOC_BIT] <= 1'b1;
			if (evtFlags.overflow)
				fp_status_control_reg[OFC_BIT] <= 1'b1;
			if (evtFlags.underflow)
				fp_status_control_reg[UFC_BIT] <= 1'b1;
			if (evtFlags.inexact)
				fp_status_control_reg[IXC_BIT] <= 1'b1;
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	assign irqSet = {evtFlags.inexact, evtFlags.underflow, evtFlags.overflow,
		evtFlags.invalid, undefEvt, doneEvt};

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irqStatus <= '0;
		else if (wrEn && paddr == OFS_IRQSTAT)
			irqStatus <= (irqStatus & ~pwdata[IRQ_W-1:0]) | irqSet;
		else
			irqStatus <= irqStatus | irqSet;
	end

	// Level interrupt while any unmasked status bit is set
	assign irq = |(irqStatus & irqMask);

	// Double zero in, same zero out
	chk_zero_sign_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(launch && !isUndef && wcmd.precision_select_bit && operand[62:0] == 63'h0)
		|=> (result == $past(operand)))
		else $error("zero operand lost its sign or value");

	// Single infinity in, same infinity out with no flags
	chk_inf_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(launch && !isUndef && !wcmd.precision_select_bit && operand[30:0] == 31'h7f80_0000)
		|=> (result[31:0] == $past(operand[31:0])) && (evtFlags == '0))
		else $error("infinity not passed through cleanly");

	// Only the exact variant may flag inexact
	chk_no_inexact: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(launch && wcmd.variant != VAR_EXACT) |=> !evtFlags.inexact)
		else $error("inexact raised by a non-exact variant");

	// Command with access disabled leaves result untouched and raises the trap event
	chk_undef_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(launch && !fpAccessEnable) |=> undefEvt && !doneEvt && $stable(result))
		else $error("disabled access did not trap cleanly");

	// Double on a single-only build is refused
	chk_sp_only_undef: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(launch && SINGLE_ONLY && wcmd.precision_select_bit) |=> undefEvt)
		else $error("double accepted on single-only build");

	// Destination index formation for single precision
	chk_dst_index: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(launch && !isUndef && !wcmd.precision_select_bit)
		|=> dstIndex == {$past(wcmd.destination_reg_index), $past(wcmd.dstHi)})
		else $error("single destination index misformed");

	// Truncate bit forces toward zero; otherwise status mode is used
	chk_trunc_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wcmd.variant == VAR_ZEROSTAT) |-> (effMode == (wcmd.truncate_select_bit ? RND_ZERO
		: fp_status_control_reg[RMODE_LSB+1:RMODE_LSB])))
		else $error("zero/status mode chosen wrongly");

	// Exact variant follows the status register mode without ties-away
	chk_status_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wcmd.variant == VAR_EXACT) |-> !effAway
		&& effMode == fp_status_control_reg[RMODE_LSB+1:RMODE_LSB])
		else $error("exact variant mode wrong");

	// Completion raises the sticky done bit and holds it two cycles on
	chk_done_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		doneEvt ##1 !(wrEn && paddr == OFS_IRQSTAT) |-> irqStatus[IRQ_DONE] [*2])
		else $error("done status not sticky");

	// Single zero in, same zero out with the upper word clear
	chk_zero_sign_sp: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(launch && !isUndef && !wcmd.precision_select_bit && operand[30:0] == 31'h0)
		|=> (result == {32'h0, $past(operand[31:0])}))
		else $error("single zero operand not kept");

	// Double infinity in, same infinity out with no flags
	chk_inf_kept_dp: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(launch && !isUndef && wcmd.precision_select_bit
		&& operand[62:0] == 63'h7ff0_0000_0000_0000)
		|=> (result == $past(operand)) && (evtFlags == '0))
		else $error("double infinity not passed through cleanly");

	// Inexact event marks the cumulative bit and the interrupt status bit
	chk_inexact_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		evtFlags.inexact |=> fp_status_control_reg[IXC_BIT] && irqStatus[IRQ_INEXACT])
		else $error("inexact event not recorded");
endmodule

// file: verification/fpri_issuer.sv
// APB issuing model standing in for the decoder and register file
`timescale 1ns/100ps
module fpri_issuer
(
	input wire logic clk_sys,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [7:0] paddr = 8'h00,
	output logic [31:0] pwdata = 32'h0000_0000,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic timedOut = 1'b0
);
	// One transfer: setup cycle, then access held until ready is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		@(posedge clk_sys);
		// Commands go out one at a time, never inside a conditional block
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		// Bounded wait for the slave answer
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		timedOut = (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		// Released address and data lines show the inverse so stale values are never trusted
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		paddr <= ~a;
	endtask
endmodule

// file: verification/fp_round_to_integral_bench.sv
// Self-checking bench for the round-to-integral unit with an integer model
`timescale 1ns/100ps
`define CHK(nm, want, got) \
	begin \
		checks++; \
		if ((got) !== (want)) \
		begin \
			failures++; \
			$display("mismatch %s exp %h got %h", nm, want, got); \
		end \
	end
module fp_round_to_integral_bench
	import fpri_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq, timedOut;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	// Bench state: read data, error, seed, counters
	logic [31:0] rdata;
	logic lastErr;
	logic [31:0] seed = 32'h0001_38c1;
	logic [31:0] x;
	fpri_cmd_t c;
	int k, m;
	int failures = 0;
	int checks = 0;
	// Directed select to model mode: away, even, plus, minus
	int dmap[4] = '{4, 0, 1, 2};

	always #10 clk_sys = ~clk_sys;

	fp_round_to_integral fp_round_to_integral_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	fpri_issuer fpri_issuer_i (.clk_sys(clk_sys), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timedOut(timedOut));

	// Xorshift source
	function automatic logic [31:0] rand32();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Round k/4 to integral; modes 0 even, 1 plus, 2 minus, 3 zero, 4 away
	function automatic int rnd(int k, int m);
		int fl;
		int r;
		fl = k >>> 2;
		r = k - 4 * fl;
		case (m)
			0: return (r < 2) ? fl : (r > 2) ? fl + 1 : fl + (fl & 1);
			1: return fl + int'(r != 0);
			2: return fl;
			3: return (k < 0) ? fl + int'(r != 0) : fl;
			default: return (r < 2) ? fl : (r > 2 || k > 0) ? fl + 1 : fl;
		endcase
	endfunction

	// Encode a real in the chosen precision; zero keeps the given sign
	function automatic logic [63:0] fbits(real v, logic neg, logic dp);
		logic [63:0] b;
		b = $realtobits(v);
		if (v == 0.0)
			return dp ? {neg, 63'h0} : {32'h0, neg, 31'h0};
		// Quarter values fit a single exactly: rebias the exponent, cut the fraction
		return dp ? b : {32'h0, b[63], 8'(b[62:52] - 11'd896), b[51:29]};
	endfunction

	task automatic final_report();
		if (timedOut)
			failures++;
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One APB transfer through the issuer
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		fpri_issuer_i.xfer(w, a, d, rdata, lastErr);
		if (timedOut)
			final_report();
	endtask

	// Issue one command and compare result, indices, flags and interrupt
	task automatic run(input fpri_cmd_t c, input logic [63:0] op, input logic [63:0] e,
		input logic [3:0] fl);
		logic [4:0] di;
		logic [4:0] si;
		logic dp;
		dp = c.precision_select_bit;
		di = dp ? {c.dstHi, c.destination_reg_index} : {c.destination_reg_index, c.dstHi};
		si = dp ? {c.srcHi, c.source_reg_index} : {c.source_reg_index, c.srcHi};
		bus(1'b1, OFS_OPLO, op[31:0]);
		bus(1'b1, OFS_OPHI, op[63:32]);
		bus(1'b1, OFS_CMD, {16'h0000, c});
		bus(1'b0, OFS_RESLO, 32'h0);
		`CHK("reslo", e[31:0], rdata)
		bus(1'b0, OFS_RESHI, 32'h0);
		`CHK("reshi", e[63:32], rdata)
		bus(1'b0, OFS_RESINFO, 32'h0);
		`CHK("index", {si, di}, rdata[9:0])
		`CHK("flags", fl, rdata[13:10])
		bus(1'b0, OFS_IRQSTAT, 32'h0);
		`CHK("irqstat", {fl, 2'b01}, rdata[5:0])
		`CHK("irq", 1'b1, irq)
		// Clear every status bit and see the line drop
		bus(1'b1, OFS_IRQSTAT, 32'h0000_003f);
		@(negedge clk_sys);
		`CHK("irqclr", 1'b0, irq)
	endtask

	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		// Reset values
		bus(1'b0, OFS_STATCTL, 32'h0);
		`CHK("statctl", STATCTL_RESET, rdata)
		bus(1'b0, OFS_IRQSTAT, 32'h0);
		`CHK("irqrst", 32'h0, rdata)
		// Command while access is disabled traps and leaves the result alone
		c = '0;
		c.variant = 2'h1;
		bus(1'b1, OFS_OPLO, 32'h3fc0_0000);
		bus(1'b1, OFS_CMD, {16'h0000, c});
		bus(1'b0, OFS_RESINFO, 32'h0);
		`CHK("undef", 1'b1, rdata[14])
		bus(1'b0, OFS_RESLO, 32'h0);
		`CHK("kept", 32'h0, rdata)
		bus(1'b0, OFS_IRQSTAT, 32'h0);
		`CHK("undefirq", 1'b1, rdata[1])
		`CHK("masked", 1'b0, irq)
		bus(1'b1, OFS_IRQMASK, 32'h0000_0002);
		@(negedge clk_sys);
		`CHK("unmasked", 1'b1, irq)
		bus(1'b1, OFS_IRQSTAT, 32'h0000_003f);
		// Unmapped place answers with an error and zero data
		bus(1'b0, 8'h40, 32'h0);
		`CHK("slverr", 1'b1, lastErr)
		`CHK("unmapped", 32'h0, rdata)
		// Enable access, interrupt on completion
		bus(1'b1, OFS_CTRL, 32'h0000_0001);
		bus(1'b1, OFS_IRQMASK, 32'h0000_0001);
		bus(1'b1, OFS_STATCTL, 32'h0);
		// Special operands: signed zero, infinity, signalling NaN
		c.precision_select_bit = 1'b1;
		run(c, 64'h8000_0000_0000_0000, 64'h8000_0000_0000_0000, 4'h0);
		run(c, 64'hfff0_0000_0000_0000, 64'hfff0_0000_0000_0000, 4'h0);
		run(c, 64'h7ff4_0000_0000_0000, 64'h7ffc_0000_0000_0000, 4'h1);
		c.precision_select_bit = 1'b0;
		c.variant = 2'h0;
		run(c, 64'h0000_0000_8000_0000, 64'h0000_0000_8000_0000, 4'h0);
		run(c, 64'h0000_0000_7f80_0000, 64'h0000_0000_7f80_0000, 4'h0);
		// Variant code three is refused even with access on
		c.variant = 2'h3;
		bus(1'b1, OFS_CMD, {16'h0000, c});
		bus(1'b0, OFS_RESINFO, 32'h0);
		`CHK("undefcode", 1'b1, rdata[14])
		bus(1'b0, OFS_RESLO, 32'h0);
		`CHK("keptinf", 32'h7f80_0000, rdata)
		bus(1'b1, OFS_IRQSTAT, 32'h0000_003f);
		// Random quarters over variant codes zero to two, every mode and precision
		for (int i = 0; i < 48; i++)
		begin
			x = rand32();
			c = fpri_cmd_t'(x[31:16]);
			if (c.variant == 2'h3)
				c.variant = 2'h1;
			k = int'(x[7:0]) - 128;
			bus(1'b1, OFS_STATCTL, {8'h00, x[9:8], 22'h0});
			if (c.variant == 2'h0)
				m = dmap[c.directed_round_select];
			else if (c.variant == 2'h2 && c.truncate_select_bit)
				m = 3;
			else
				m = int'(x[9:8]);
			run(c, fbits(k / 4.0, 1'b0, c.precision_select_bit),
				fbits(rnd(k, m), k < 0, c.precision_select_bit),
				{c.variant == 2'h1 && (k & 3) != 0, 3'h0});
		end
		final_report();
	end
endmodule
